// File: core/dac_word_regs.vh
// constants for the eight-channel converter word port
`ifndef DAC_WORD_REGS_VH
`define DAC_WORD_REGS_VH
`define WORD_W 16
`define DATA_W 12
`define DATA_LSB 0
`define DATA_MSB 11
`define SEL_LSB 12
`define SEL_MSB 14
`define SEL_W 3
`define ENABLE_BIT 15
`define NUM_CH 8
`define ZERO_CODE 12'h000
`define FULL_CODE 12'hfff
`define RANGE_5V 1'b1
`endif

// File: core/eight_channel_dac_word_port.v
// word port front end for an eight-channel 12-bit voltage output module
// What this block does
// - controller drives a 16-bit word; all sixteen bits sampled together.
// - bits 14..12 of the word pick the destination channel.
// - select field is unsigned, bit 14 msb; 0 is channel 1, 7 channel 8.
// - bit 15 is one output enable shared by all eight channels.
// - enable low forces every channel output to code zero.
// - disable clears all eight channel data registers to zero.
// - after re-enable each channel stays zero until written anew.
// - bits 11..0 are unsigned data, bit n weighing two to the n.
// - data codes run 000 to fff, no sign or offset.
// - code zero is zero volts, fff full scale, linear between.
// - updates in any order touch only the selected channel.
// - one range setting serves all channels: 0-5 v or 0-10 v.
`include "dac_word_regs.vh"
module eight_channel_dac_word_port (
  input wire mclk_in,
  input wire rst_b_in,
  input wire clk_en_in,
  input wire [15:0] out_word_in,
  input wire range_5v_in,
  output wire [95:0] ch_code_out,
  output wire [7:0] ch_load_out,
  output wire outputs_on_out,
  output wire range_5v_out
);

  reg rst_meta_reg;
  reg rst_sync_reg;
  reg [15:0] word_meta_reg;
  reg [15:0] word_sync_reg;
  reg range_meta_reg;
  reg range_sync_reg;
  reg range_reg;
  reg range_next;
  reg enable_reg;
  reg enable_next;
  reg [7:0] load_reg;
  reg [7:0] load_next;
  reg [11:0] ch0_reg;
  reg [11:0] ch1_reg;
  reg [11:0] ch2_reg;
  reg [11:0] ch3_reg;
  reg [11:0] ch4_reg;
  reg [11:0] ch5_reg;
  reg [11:0] ch6_reg;
  reg [11:0] ch7_reg;
  reg [11:0] ch0_next;
  reg [11:0] ch1_next;
  reg [11:0] ch2_next;
  reg [11:0] ch3_next;
  reg [11:0] ch4_next;
  reg [11:0] ch5_next;
  reg [11:0] ch6_next;
  reg [11:0] ch7_next;
  wire rst_b;
  wire word_enable;
  wire [2:0] word_sel;
  wire [11:0] word_data;
  wire [7:0] word_hit;

  // one-hot decode of the select field, value 0 picks channel 1
  function [7:0] sel_decode;
    input [2:0] sel;
    begin
      sel_decode = 8'h01 << sel;
    end
  endfunction

  // next code of one channel: cleared when disabled, loaded when picked
  function [11:0] chan_next;
    input [11:0] cur;
    input [11:0] data;
    input en;
    input hit;
    begin
      if (!en) begin
        chan_next = `ZERO_CODE;
      end else if (hit) begin
        chan_next = data;
      end else begin
        chan_next = cur;
      end
    end
  endfunction

  // reset release through two flip-flops
  always @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end
  assign rst_b = rst_sync_reg;

  // the word comes from pins: whole word synchronised together
  always @(posedge mclk_in or negedge rst_b) begin
    if (!rst_b) begin
      word_meta_reg <= 16'h0000;
      word_sync_reg <= 16'h0000;
      range_meta_reg <= `RANGE_5V;
      range_sync_reg <= `RANGE_5V;
    end else if (clk_en_in) begin
      word_meta_reg <= out_word_in;
      word_sync_reg <= word_meta_reg;
      range_meta_reg <= range_5v_in;
      range_sync_reg <= range_meta_reg;
    end
  end

  assign word_enable = word_sync_reg[`ENABLE_BIT];
  assign word_sel = word_sync_reg[`SEL_MSB:`SEL_LSB];
  assign word_data = word_sync_reg[`DATA_MSB:`DATA_LSB];
  assign word_hit = sel_decode(word_sel);

  // next values of the shared state
  always @* begin
    enable_next = word_enable;
    range_next = range_sync_reg;
    if (word_enable) begin
      load_next = word_hit;
    end else begin
      load_next = 8'h00;
    end
  end

  // next values of the eight channel registers
  always @* begin
    ch0_next = chan_next(ch0_reg, word_data, word_enable, word_hit[0]);
    ch1_next = chan_next(ch1_reg, word_data, word_enable, word_hit[1]);
    ch2_next = chan_next(ch2_reg, word_data, word_enable, word_hit[2]);
    ch3_next = chan_next(ch3_reg, word_data, word_enable, word_hit[3]);
    ch4_next = chan_next(ch4_reg, word_data, word_enable, word_hit[4]);
    ch5_next = chan_next(ch5_reg, word_data, word_enable, word_hit[5]);
    ch6_next = chan_next(ch6_reg, word_data, word_enable, word_hit[6]);
    ch7_next = chan_next(ch7_reg, word_data, word_enable, word_hit[7]);
  end

  // shared state: enable copy, range, load strobes
  always @(posedge mclk_in or negedge rst_b) begin
    if (!rst_b) begin
      enable_reg <= 1'b0;
      range_reg <= `RANGE_5V;
      load_reg <= 8'h00;
    end else if (clk_en_in) begin
      enable_reg <= enable_next;
      range_reg <= range_next;
      load_reg <= load_next;
    end
  end

  // channel 1 register
  always @(posedge mclk_in or negedge rst_b) begin
    if (!rst_b) begin
      ch0_reg <= `ZERO_CODE;
    end else if (clk_en_in) begin
      ch0_reg <= ch0_next;
    end
  end

  // channel 2 register
  always @(posedge mclk_in or negedge rst_b) begin
    if (!rst_b) begin
      ch1_reg <= `ZERO_CODE;
    end else if (clk_en_in) begin
      ch1_reg <= ch1_next;
    end
  end

  // channel 3 register
  always @(posedge mclk_in or negedge rst_b) begin
    if (!rst_b) begin
      ch2_reg <= `ZERO_CODE;
    end else if (clk_en_in) begin
      ch2_reg <= ch2_next;
    end
  end

  // channel 4 register
  always @(posedge mclk_in or negedge rst_b) begin
    if (!rst_b) begin
      ch3_reg <= `ZERO_CODE;
    end else if (clk_en_in) begin
      ch3_reg <= ch3_next;
    end
  end

  // channel 5 register
  always @(posedge mclk_in or negedge rst_b) begin
    if (!rst_b) begin
      ch4_reg <= `ZERO_CODE;
    end else if (clk_en_in) begin
      ch4_reg <= ch4_next;
    end
  end

  // channel 6 register
  always @(posedge mclk_in or negedge rst_b) begin
    if (!rst_b) begin
      ch5_reg <= `ZERO_CODE;
    end else if (clk_en_in) begin
      ch5_reg <= ch5_next;
    end
  end

  // channel 7 register
  always @(posedge mclk_in or negedge rst_b) begin
    if (!rst_b) begin
      ch6_reg <= `ZERO_CODE;
    end else if (clk_en_in) begin
      ch6_reg <= ch6_next;
    end
  end

  // channel 8 register
  always @(posedge mclk_in or negedge rst_b) begin
    if (!rst_b) begin
      ch7_reg <= `ZERO_CODE;
    end else if (clk_en_in) begin
      ch7_reg <= ch7_next;
    end
  end

  // codes leave straight from the channel registers
  assign ch_code_out = {ch7_reg, ch6_reg, ch5_reg, ch4_reg,
                        ch3_reg, ch2_reg, ch1_reg, ch0_reg};
  assign ch_load_out = load_reg;
  assign outputs_on_out = enable_reg;
  assign range_5v_out = range_reg;

endmodule

// File: tb/word_port_checker.sv
// assertions on the word port outputs
module wp_chk(input wire mclk_in, rst_b_in, clk_en_in, range_5v_in,
  outputs_on_out, range_5v_out, input wire [15:0] out_word_in,
  input wire [95:0] ch_code_out, input wire [7:0] ch_load_out);
  timeunit 1ns; timeprecision 1ps;
  logic [47:0] p;
  logic [4:0] rst_q;
  wire [15:0] w = p[47:32];
  wire [6:0] s = 7'(w[14:12]) * 7'd12;
  wire [95:0] m = ~(96'hfff << s);
  // word pipeline follows the design's frozen cycles
  always @(posedge mclk_in) if (clk_en_in) p <= {p[31:0], out_word_in};
  // checks wait until the pin word has reached the outputs after reset
  always @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in) rst_q <= 5'h00;
    else rst_q <= {rst_q[3:0], 1'b1};
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_q[4] || !clk_en_in);
  a_en_copy: assert property (outputs_on_out == w[15])
    else $error("bad enable");
  a_sel_decode: assert property
    (ch_load_out == (w[15] ? 8'h1 << w[14:12] : 8'h0)) else $error("bad load");
  a_off_zero: assert property (!outputs_on_out |-> ch_code_out == 0)
    else $error("not zero");
  a_new_zero: assert property
    ($rose(outputs_on_out) |-> (ch_code_out & m) == 0) else $error("stale");
  a_data_store: assert property
    (|ch_load_out |-> ch_code_out[s+:12] == w[11:0]) else $error("bad data");
  a_others_hold: assert property (|ch_load_out |->
    ((ch_code_out ^ $past(ch_code_out)) & m) == 0) else $error("moved");
  a_load_en: assert property (|ch_load_out |-> outputs_on_out)
    else $error("load off");
  a_range_sync: assert property
    ($rose(range_5v_in) |-> ##[1:4] range_5v_out) else $error("range");
  cover property (ch_load_out[7]);
  cover property ($fell(outputs_on_out));
  cover property ($rose(range_5v_out));
endmodule
bind eight_channel_dac_word_port wp_chk wp_chk_inst(
  .mclk_in(mclk_in),
  .rst_b_in(rst_b_in),
  .clk_en_in(clk_en_in),
  .range_5v_in(range_5v_in),
  .outputs_on_out(outputs_on_out),
  .range_5v_out(range_5v_out),
  .out_word_in(out_word_in),
  .ch_code_out(ch_code_out),
  .ch_load_out(ch_load_out)
);

// File: tb/ctl_model.sv
// controller model driving the sixteen output points
module ctl_model(input wire mclk_in, output logic [15:0] out_word_in);
  timeunit 1ns; timeprecision 1ps;
  initial out_word_in = 16'h0000;
  task put(input logic [15:0] d); // one word per scan
    @(negedge mclk_in) out_word_in = d; // all bits at once
    repeat (4) @(negedge mclk_in);
  endtask
endmodule

// File: tb/eight_channel_dac_word_port_test.sv
// bench for the word port
module eight_channel_dac_word_port_test;
  timeunit 1ns; timeprecision 1ps;
  logic mclk_in = 0, rst_b_in = 0, clk_en_in = 1, range_5v_in = 1;
  wire [15:0] out_word_in;
  wire [95:0] ch_code_out;
  wire [7:0] ch_load_out;
  wire outputs_on_out, range_5v_out;
  logic [95:0] x = 0;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  ctl_model ctl_model_inst(
    .mclk_in(mclk_in),
    .out_word_in(out_word_in)
  );
  eight_channel_dac_word_port eight_channel_dac_word_port_inst(
    .mclk_in(mclk_in),
    .rst_b_in(rst_b_in),
    .clk_en_in(clk_en_in),
    .out_word_in(out_word_in),
    .range_5v_in(range_5v_in),
    .ch_code_out(ch_code_out),
    .ch_load_out(ch_load_out),
    .outputs_on_out(outputs_on_out),
    .range_5v_out(range_5v_out)
  );
  initial forever #12.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (++cyc > 999) begin
    error_cnt++;
    print_verdict;
  end
  task chk(string n, logic [95:0] e, logic [95:0] v);
    n_checks++;
    if (v !== e) begin
      error_cnt++;
      $display("mismatch %s exp %h seen %h", n, e, v);
    end
  endtask
  task wr(logic [15:0] d);
    ctl_model_inst.put(d);
    if (d[15]) x[d[14:12]*12+:12] = d[11:0]; else x = 0;
    chk("code", x, ch_code_out);
    chk("load", {7'h00, d[15]} << d[14:12], ch_load_out);
    chk("on", d[15], outputs_on_out);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task test_fill;
    for (int k = 0; k < 8; k++) wr({1'b1, 3'(k), 12'h1 << k});
    wr(16'hffff);
    wr(16'hb5a5);
    wr(16'h8123);
    $display("fill and order done");
  endtask
  task test_disable;
    wr(16'h7abc);
    wr(16'ha00f);
    $display("disable done");
  endtask
  task test_freeze;
    clk_en_in = 0;
    ctl_model_inst.put(16'h8fed);
    chk("frozen", x, ch_code_out);
    clk_en_in = 1;
    ctl_model_inst.put(16'h8fed);
    x[11:0] = 12'hfed;
    chk("thawed", x, ch_code_out);
    $display("freeze done");
  endtask
  task test_range;
    range_5v_in = 0;
    repeat (5) @(negedge mclk_in);
    chk("range", 0, range_5v_out);
    range_5v_in = 1;
    repeat (5) @(negedge mclk_in);
    chk("range", 1, range_5v_out);
    $display("range done");
  endtask
  task test_reset;
    rst_b_in = 0;
    repeat (3) @(negedge mclk_in);
    chk("reset code", 0, ch_code_out);
    chk("reset on", 0, outputs_on_out);
    rst_b_in = 1;
    repeat (2) @(negedge mclk_in);
    x = 0;
    wr(16'h8fed);
    $display("reset done");
  endtask
  initial begin
    repeat (10) @(negedge mclk_in);
    rst_b_in = 1;
    repeat (3) @(negedge mclk_in);
    test_fill;
    test_disable;
    test_freeze;
    test_range;
    test_reset;
    print_verdict;
  end
endmodule
